// [hw/cgcmd_cfg.svh]
/*
 constants of the clock-generator command layer: bus address, command codes,
 byte positions in a frame, timing figures.
 assumes: included by bare name from the design files.
*/
// What this block does
// - answer only to the fixed 7-bit address; master puts it first, then read/write bit
// - write frame: address+0, command ending 00, pointer byte, data; every byte acknowledged
// - keep storing data bytes until stop, pointer plus one after each byte
// - pointer held between frames; a bare read starts one above last register used
// - a repeated start may follow the pointer acknowledge; the read frame is then accepted
// - read frame returns identity byte then registers; master ends with no-ack and stop
// - command ending 01 copies all configuration registers into non-volatile memory
// - command ending 10 loads all non-volatile memory back into the registers
// - save or restore starts only after the stop ending the command frame
// - while save or restore runs no acknowledge is driven at all
// - when the copy is done the address is acknowledged again
// - at power-up the memory is loaded into the registers without any command
// - address not acknowledged until the power-up load ends
`ifndef CGCMD_CFG_SVH
`define CGCMD_CFG_SVH
`define CG_SLAVE_ADDR 7'h6A
// identity byte, value arbitrary
`define CG_IDENT_BYTE 8'h5A
`define CG_CMD_WRITE 2'h0
`define CG_CMD_SAVE 2'h1
`define CG_CMD_LOAD 2'h2
`define CG_ACK_BIT 4'h8
`define CG_BYTE_ADDR 2'h0
`define CG_BYTE_CMD 2'h1
`define CG_BYTE_PTR 2'h2
`define CG_BYTE_DATA 2'h3
`define CG_SYNC_IDLE 3'h7
`define CG_MCLK_NS 5
`define CG_NVM_WR_NS 100
`define CG_NVM_ERASED 8'hFF
`endif

// [hw/cgcmd_link.sv]
/*
 bit capture in the serial clock domain: samples the data line at each rising edge and
 flips a toggle that the system clock side synchronises.
 assumes: i_scl_clk is the bus clock pin, i_rst an asynchronous clear.
*/
`timescale 1ns/100ps
module cgcmd_link
(
   input wire logic i_scl_clk,
   input wire logic i_rst,
   input wire logic i_sda,
   output logic o_bit,
   output logic o_tog
);
   import cgcmd_pkg::*;
   typedef struct packed
   {
      logic bitv;
      logic tog;
   } cgcmd_link_st_t;
   cgcmd_link_st_t r_reg;
   cgcmd_link_st_t r_next;
   // -------------------------------------------------
   // capture
   // -------------------------------------------------
   always_comb
   begin
      r_next.bitv = i_sda;
      r_next.tog = ~r_reg.tog;
   end
   always_ff @(posedge i_scl_clk or posedge i_rst)
   begin
      if (i_rst)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end
   assign o_bit = r_reg.bitv;
   assign o_tog = r_reg.tog;
endmodule

// [hw/cgcmd_nvm.sv]
/*
 non-volatile store of the configuration: one byte per request, reads answer
 next cycle, writes answer after the programming time.
 assumes: one request at a time, next only after o_done.
*/
`timescale 1ns/100ps
`include "cgcmd_cfg.svh"
module cgcmd_nvm
#(
   parameter int PTR_W = 8,
   parameter int WR_CYC = (`CG_NVM_WR_NS + `CG_MCLK_NS - 1) / `CG_MCLK_NS
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input cgcmd_pkg::cgcmd_nvm_req_t i_req,
   output logic [7:0] o_rdata,
   output logic o_done
);
   import cgcmd_pkg::*;
   localparam int NUM_REGS = 1 << PTR_W;
   typedef struct packed
   {
      logic [15:0] cnt;
      logic done;
      logic [7:0] rdata;
   } cgcmd_nvm_st_t;
   cgcmd_nvm_st_t r_reg;
   cgcmd_nvm_st_t r_next;
   logic [7:0] mem [0:NUM_REGS-1];
   // -------------------------------------------------
   // request sequencing
   // -------------------------------------------------
   always_comb
   begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (r_reg.cnt != 16'h0000)
      begin
         r_next.cnt = r_reg.cnt - 16'h0001;
         r_next.done = (r_reg.cnt == 16'h0001);
      end
      else if (i_req.req && i_req.we)
         r_next.cnt = 16'(WR_CYC);
      else if (i_req.req)
      begin
         r_next.rdata = mem[i_req.addr[PTR_W-1:0]];
         r_next.done = 1'b1;
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end
   // -------------------------------------------------
   // storage, erased at every reset
   // -------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         for (int k = 0; k < NUM_REGS; k++)
            mem[k] <= `CG_NVM_ERASED;
      end
      else if (i_req.req && i_req.we && r_reg.cnt == 16'h0000)
         mem[i_req.addr[PTR_W-1:0]] <= i_req.wdata;
   end
   assign o_rdata = r_reg.rdata;
   assign o_done = r_reg.done;
endmodule

// [hw/cgcmd_pkg.sv]
/*
 types shared by the command layer: frame phase, copy operation, memory request.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package cgcmd_pkg;
   // -------------------------------------------------
   // enumerations
   // -------------------------------------------------
   typedef enum logic [3:0]
   {
      PH_IDLE = 4'h1,
      PH_RX = 4'h2,
      PH_TX = 4'h4,
      PH_HOLD = 4'h8
   } cgcmd_phase_t;
   typedef enum logic [2:0]
   {
      OP_NONE = 3'h1,
      OP_SAVE = 3'h2,
      OP_LOAD = 3'h4
   } cgcmd_op_t;
   // -------------------------------------------------
   // carriers
   // -------------------------------------------------
   typedef struct packed
   {
      logic req;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cgcmd_nvm_req_t;
endpackage

// [hw/cgcmd_top.sv]
/*
 serial command layer of the clock generator: byte framing of the two-wire bus,
 register file with auto-incrementing pointer, save and restore to the store.
 assumes: open-drain data line resolved outside; i_scl_clk is the bus clock pin.
*/
`timescale 1ns/100ps
`include "cgcmd_cfg.svh"
module cgcmd_top
#(
   parameter int PTR_W = 8
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_scl_clk,
   input wire logic i_sda_i,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic [PTR_W-1:0] i_cfg_addr,
   output logic [7:0] o_cfg_data,
   output logic o_busy
);
   import cgcmd_pkg::*;
   localparam int NUM_REGS = 1 << PTR_W;
   localparam logic [PTR_W-1:0] IDX_LAST = '1;
   localparam logic [PTR_W-1:0] PTR_ONE = {{(PTR_W-1){1'b0}}, 1'b1};
   typedef struct packed
   {
      logic [2:0] scl_p;
      logic [2:0] sda_p;
      logic [2:0] tog_p;
      cgcmd_phase_t phase;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic [1:0] bidx;
      logic rw;
      logic [1:0] cmd;
      logic [PTR_W-1:0] ptr;
      logic [7:0] tx;
      logic need_ld;
      logic first;
      logic sda_oe;
      logic busy;
      cgcmd_op_t op;
      logic [PTR_W-1:0] idx;
      logic nvm_wait;
      logic [7:0] cfg_data;
   } cgcmd_main_st_t;
   localparam cgcmd_main_st_t ST_RST = '{scl_p: `CG_SYNC_IDLE, sda_p: `CG_SYNC_IDLE,
      tog_p: 3'h0, phase: PH_IDLE, bitcnt: 4'h0, shift: 8'h00, bidx: `CG_BYTE_ADDR,
      rw: 1'b0, cmd: `CG_CMD_WRITE, ptr: '0, tx: 8'h00, need_ld: 1'b0, first: 1'b0,
      sda_oe: 1'b0, busy: 1'b1, op: OP_LOAD, idx: '0, nvm_wait: 1'b0, cfg_data: 8'h00};
   cgcmd_main_st_t r_reg;
   cgcmd_main_st_t r_next;
   logic [7:0] regs [0:NUM_REGS-1];
   logic lbit;
   logic ltog;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic bit_ev;
   logic addr_hit;
   logic nvm_go;
   logic bus_wr;
   logic ld_ev;
   logic [7:0] tx_byte;
   logic wr_en;
   logic [PTR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   cgcmd_nvm_req_t nvm_req;
   logic [7:0] nvm_rdata;
   logic nvm_done;
   // -------------------------------------------------
   // link domain and store
   // -------------------------------------------------
   cgcmd_link u_link
   (
      .i_scl_clk(i_scl_clk),
      .i_rst(i_reset),
      .i_sda(i_sda_i),
      .o_bit(lbit),
      .o_tog(ltog)
   );
   cgcmd_nvm #(.PTR_W(PTR_W)) u_nvm
   (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_req(nvm_req),
      .o_rdata(nvm_rdata),
      .o_done(nvm_done)
   );
   // -------------------------------------------------
   // bus events
   // -------------------------------------------------
   assign scl_fall = r_reg.scl_p[2] & ~r_reg.scl_p[1];
   assign start_ev = r_reg.scl_p[1] & r_reg.sda_p[2] & ~r_reg.sda_p[1];
   assign stop_ev = r_reg.scl_p[1] & ~r_reg.sda_p[2] & r_reg.sda_p[1];
   assign bit_ev = r_reg.tog_p[1] ^ r_reg.tog_p[2];
   assign addr_hit = (r_reg.shift[7:1] == `CG_SLAVE_ADDR) && !r_reg.busy;
   assign nvm_go = stop_ev && !r_reg.busy && !r_reg.rw && r_reg.phase == PH_RX
      && (r_reg.bidx == `CG_BYTE_PTR || r_reg.bidx == `CG_BYTE_DATA)
      && (r_reg.cmd == `CG_CMD_SAVE || r_reg.cmd == `CG_CMD_LOAD);
   assign ld_ev = r_reg.phase == PH_TX && !bit_ev && scl_fall && r_reg.need_ld && !start_ev
      && !stop_ev;
   assign tx_byte = r_reg.first ? `CG_IDENT_BYTE : regs[r_reg.ptr];
   assign nvm_req.req = r_reg.busy && !r_reg.nvm_wait;
   assign nvm_req.we = (r_reg.op == OP_SAVE);
   assign nvm_req.addr = 8'(r_reg.idx);
   assign nvm_req.wdata = regs[r_reg.idx];
   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb
   begin
      r_next = r_reg;
      bus_wr = 1'b0;
      wr_en = 1'b0;
      wr_addr = r_reg.ptr;
      wr_data = r_reg.shift;
      r_next.scl_p = {r_reg.scl_p[1:0], i_scl_clk};
      r_next.sda_p = {r_reg.sda_p[1:0], i_sda_i};
      r_next.tog_p = {r_reg.tog_p[1:0], ltog};
      r_next.cfg_data = regs[i_cfg_addr];
      // copy engine
      if (r_reg.busy && r_reg.nvm_wait && nvm_done)
      begin
         r_next.nvm_wait = 1'b0;
         if (r_reg.op == OP_LOAD)
         begin
            wr_en = 1'b1;
            wr_addr = r_reg.idx;
            wr_data = nvm_rdata;
         end
         if (r_reg.idx == IDX_LAST)
         begin
            r_next.busy = 1'b0;
            r_next.op = OP_NONE;
         end
         else
            r_next.idx = r_reg.idx + PTR_ONE;
      end
      else if (r_reg.busy && !r_reg.nvm_wait)
         r_next.nvm_wait = 1'b1;
      // framing
      if (start_ev)
      begin
         r_next.phase = PH_RX;
         r_next.bitcnt = 4'h0;
         r_next.bidx = `CG_BYTE_ADDR;
         r_next.rw = 1'b0;
         r_next.sda_oe = 1'b0;
         r_next.need_ld = 1'b0;
      end
      else if (stop_ev)
      begin
         r_next.phase = PH_IDLE;
         r_next.sda_oe = 1'b0;
         r_next.bidx = `CG_BYTE_ADDR;
         if (nvm_go)
         begin
            r_next.busy = 1'b1;
            r_next.op = (r_reg.cmd == `CG_CMD_SAVE) ? OP_SAVE : OP_LOAD;
            r_next.idx = '0;
            r_next.nvm_wait = 1'b0;
         end
      end
      else if (r_reg.phase == PH_RX && bit_ev)
      begin
         if (r_reg.bitcnt != `CG_ACK_BIT)
         begin
            r_next.shift = {r_reg.shift[6:0], lbit};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
         end
         else
         begin
            r_next.bitcnt = 4'h0;
            if (!r_reg.sda_oe)
               r_next.phase = PH_HOLD;
            else if (r_reg.rw)
            begin
               r_next.phase = PH_TX;
               r_next.need_ld = 1'b1;
               r_next.first = 1'b1;
            end
         end
      end
      else if (r_reg.phase == PH_RX && scl_fall)
      begin
         if (r_reg.bitcnt == `CG_ACK_BIT && !r_reg.sda_oe)
         begin
            r_next.sda_oe = 1'b1;
            case (r_reg.bidx)
               `CG_BYTE_ADDR:
               begin
                  r_next.sda_oe = addr_hit;
                  r_next.rw = r_reg.shift[0];
               end
               `CG_BYTE_CMD:
                  r_next.cmd = r_reg.shift[1:0];
               `CG_BYTE_PTR:
               begin
                  if (r_reg.cmd == `CG_CMD_WRITE)
                     r_next.ptr = r_reg.shift[PTR_W-1:0];
               end
               default:
               begin
                  if (r_reg.cmd == `CG_CMD_WRITE)
                  begin
                     bus_wr = 1'b1;
                     wr_en = 1'b1;
                     r_next.ptr = r_reg.ptr + PTR_ONE;
                  end
               end
            endcase
            if (r_reg.bidx != `CG_BYTE_DATA)
               r_next.bidx = r_reg.bidx + 2'h1;
         end
         else if (r_reg.bitcnt == 4'h0)
            r_next.sda_oe = 1'b0;
      end
      else if (r_reg.phase == PH_TX && bit_ev)
      begin
         if (r_reg.bitcnt != `CG_ACK_BIT)
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
         else
         begin
            r_next.bitcnt = 4'h0;
            if (lbit)
               r_next.phase = PH_HOLD;
            else
               r_next.need_ld = 1'b1;
         end
      end
      else if (r_reg.phase == PH_TX && scl_fall)
      begin
         if (r_reg.need_ld)
         begin
            r_next.tx = tx_byte;
            r_next.sda_oe = ~tx_byte[7];
            r_next.need_ld = 1'b0;
            r_next.first = 1'b0;
            if (!r_reg.first)
               r_next.ptr = r_reg.ptr + PTR_ONE;
         end
         else if (r_reg.bitcnt == `CG_ACK_BIT)
            r_next.sda_oe = 1'b0;
         else
         begin
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.tx[6];
         end
      end
   end
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         r_reg <= ST_RST;
      else
         r_reg <= r_next;
   end
   always_ff @(posedge i_mclk)
   begin
      if (wr_en)
         regs[wr_addr] <= wr_data;
   end
   assign o_sda_o = 1'b0;
   assign o_sda_oe = r_reg.sda_oe;
   assign o_cfg_data = r_reg.cfg_data;
   assign o_busy = r_reg.busy;
   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   property p_addr_ack;
      @(posedge i_mclk) disable iff (i_reset)
      (r_reg.phase == PH_RX && scl_fall && !start_ev && !stop_ev
         && r_reg.bitcnt == `CG_ACK_BIT && r_reg.bidx == `CG_BYTE_ADDR && !r_reg.sda_oe)
      |=> (r_reg.sda_oe == $past(addr_hit));
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
   property p_busy_quiet;
      @(posedge i_mclk) disable iff (i_reset)
      r_reg.busy |-> !r_reg.sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("drive while copying");
   property p_op_after_stop;
      @(posedge i_mclk) disable iff (i_reset)
      $rose(r_reg.busy) |-> $past(stop_ev);
   endproperty
   a_op_after_stop: assert property (p_op_after_stop) else $error("copy without stop");
   property p_ptr_step;
      @(posedge i_mclk) disable iff (i_reset)
      bus_wr |=> (r_reg.ptr - $past(r_reg.ptr)) == PTR_ONE;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");
   property p_write_cmd;
      @(posedge i_mclk) disable iff (i_reset)
      bus_wr |-> (r_reg.cmd == `CG_CMD_WRITE && !r_reg.rw);
   endproperty
   a_write_cmd: assert property (p_write_cmd) else $error("write under other command");
   property p_save_go;
      @(posedge i_mclk) disable iff (i_reset)
      (nvm_go && r_reg.cmd == `CG_CMD_SAVE) |=> (r_reg.busy && r_reg.op == OP_SAVE);
   endproperty
   a_save_go: assert property (p_save_go) else $error("save not started");
   property p_load_go;
      @(posedge i_mclk) disable iff (i_reset)
      (nvm_go && r_reg.cmd == `CG_CMD_LOAD) |=> (r_reg.busy && r_reg.op == OP_LOAD);
   endproperty
   a_load_go: assert property (p_load_go) else $error("restore not started");
   property p_done_release;
      @(posedge i_mclk) disable iff (i_reset)
      $fell(r_reg.busy) |-> ($past(nvm_done) && $past(r_reg.idx) == IDX_LAST);
   endproperty
   a_done_release: assert property (p_done_release) else $error("copy ended early");
   property p_powerup;
      @(posedge i_mclk) disable iff (i_reset)
      $past(i_reset) |-> (r_reg.busy && r_reg.op == OP_LOAD && r_reg.idx == '0);
   endproperty
   a_powerup: assert property (p_powerup) else $error("no power-up restore");
   property p_ident_first;
      @(posedge i_mclk) disable iff (i_reset)
      (ld_ev && r_reg.first) |=> (r_reg.tx == `CG_IDENT_BYTE && r_reg.ptr == $past(r_reg.ptr));
   endproperty
   a_ident_first: assert property (p_ident_first) else $error("identity byte wrong");
   property p_read_ptr;
      @(posedge i_mclk) disable iff (i_reset)
      (ld_ev && !r_reg.first) |=> (r_reg.ptr - $past(r_reg.ptr)) == PTR_ONE;
   endproperty
   a_read_ptr: assert property (p_read_ptr) else $error("read pointer stuck");
   property p_restart;
      @(posedge i_mclk) disable iff (i_reset)
      start_ev |=> (r_reg.phase == PH_RX && r_reg.bitcnt == 4'h0 && !r_reg.sda_oe);
   endproperty
   a_restart: assert property (p_restart) else $error("start not taken");
endmodule

// [sim/cgcmd_master.sv]
/*
 bus master model: drives the serial clock and pulls the data line low.
 assumes: the bench resolves the data line with a pull-up.
*/
`timescale 1ns/100ps
module cgcmd_master
(
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   localparam int Q = 16;
   logic r;
   // clock stands high outside frames
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // start or repeated start
   task start();
      o_sda_low = 1'b0;
      #(Q);
      o_scl = 1'b1;
      #(2*Q);
      o_sda_low = 1'b1;
      #(2*Q);
      o_scl = 1'b0;
      #(Q);
   endtask
   // stop
   task stop();
      o_sda_low = 1'b1;
      #(Q);
      o_scl = 1'b1;
      #(2*Q);
      o_sda_low = 1'b0;
      #(2*Q);
   endtask
   // one clock, data set in the low phase, line sampled in the high phase
   task bit_io(input logic b, output logic s);
      o_sda_low = ~b;
      #(Q);
      o_scl = 1'b1;
      #(Q);
      s = i_sda;
      #(Q);
      o_scl = 1'b0;
      #(Q);
   endtask
   // byte msb first, returns the acknowledge seen
   task wr_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // reads a byte, acknowledges all but the last
   task rd_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask
endmodule

// [sim/tb_top.sv]
/*
 bench of the command layer: master model at the bus, checks of acknowledges,
 read bytes and register contents through the internal read port.
 assumes: design in hw/, master model in sim/; data line pulled up here.
*/
`timescale 1ns/100ps
`include "cgcmd_cfg.svh"
module tb_top;
   import cgcmd_pkg::*;
   localparam logic [7:0] AW = {`CG_SLAVE_ADDR, 1'b0};
   localparam logic [7:0] AR = {`CG_SLAVE_ADDR, 1'b1};
   logic i_mclk = 1'b0;
   logic i_reset;
   logic [7:0] i_cfg_addr = 8'h00;
   logic o_sda_o, o_sda_oe, o_busy, scl, sda_low, sda, a;
   logic [7:0] o_cfg_data, d;
   logic [7:0] pat [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   int fail_count = 0;
   int check_count = 0;
   assign sda = ~(sda_low | (o_sda_oe & ~o_sda_o));
   always #2.5 i_mclk = ~i_mclk;
   cgcmd_top #(.PTR_W(8)) cgcmd_top_i
   (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_scl_clk(scl), .i_sda_i(sda),
      .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_cfg_addr(i_cfg_addr),
      .o_cfg_data(o_cfg_data), .o_busy(o_busy)
   );
   cgcmd_master cgcmd_master_i (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (o_busy !== v && n < lim)
      begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      if (o_busy !== v)
      begin
         fail_count++;
         $display("BAD busy expected %b seen %b", v, o_busy);
         end_of_test();
      end
   endtask
   task peek(input logic [7:0] ad, input logic [7:0] e);
      @(posedge i_mclk);
      i_cfg_addr <= ad;
      repeat (2) @(posedge i_mclk);
      #1;
      chk("cfg_data", e, o_cfg_data);
   endtask
   task sa(input logic [7:0] ab, input logic e);
      @(posedge i_mclk);
      #0.7;
      cgcmd_master_i.start();
      cgcmd_master_i.wr_byte(ab, a);
      chk("addr_ack", {7'h00, e}, {7'h00, a});
   endtask
   task wb(input logic [7:0] v);
      cgcmd_master_i.wr_byte(v, a);
      chk("byte_ack", 8'h01, {7'h00, a});
   endtask
   task rb(input logic last, input logic [7:0] e);
      cgcmd_master_i.rd_byte(last, d);
      chk("read_byte", e, d);
   endtask
   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task t_powerup();
      chk("busy", 8'h01, {7'h00, o_busy});
      sa(AW, 1'b0);
      cgcmd_master_i.stop();
      wait_busy(1'b0, 5000);
      peek(8'h00, `CG_NVM_ERASED);
      peek(8'hFF, `CG_NVM_ERASED);
      $display("test powerup done");
   endtask
   task t_addr();
      sa(8'hAA, 1'b0);
      cgcmd_master_i.stop();
      sa(8'hD6, 1'b0);
      cgcmd_master_i.stop();
      sa(AW, 1'b1);
      cgcmd_master_i.stop();
      $display("test address done");
   endtask
   task t_write();
      sa(AW, 1'b1);
      wb(8'hFC);
      wb(8'hFE);
      for (int i = 0; i < 4; i++)
      begin
         wb(pat[i]);
      end
      cgcmd_master_i.stop();
      for (int i = 0; i < 4; i++)
      begin
         peek(8'(8'hFE + i), pat[i]);
      end
      $display("test write done");
   endtask
   task t_read();
      sa(AW, 1'b1);
      wb(8'h00);
      wb(8'hFE);
      cgcmd_master_i.stop();
      sa(AR, 1'b1);
      rb(1'b0, `CG_IDENT_BYTE);
      rb(1'b0, 8'h11);
      rb(1'b0, 8'h22);
      rb(1'b1, 8'h33);
      cgcmd_master_i.stop();
      sa(AR, 1'b1);
      rb(1'b0, `CG_IDENT_BYTE);
      rb(1'b1, 8'h44);
      cgcmd_master_i.stop();
      sa(AW, 1'b1);
      wb(8'h80);
      wb(8'hFF);
      sa(AR, 1'b1);
      rb(1'b0, `CG_IDENT_BYTE);
      rb(1'b0, 8'h22);
      rb(1'b1, 8'h33);
      cgcmd_master_i.stop();
      $display("test read done");
   endtask
   task t_undef();
      sa(AW, 1'b1);
      wb(8'hFF);
      wb(8'h77);
      cgcmd_master_i.stop();
      repeat (40) @(posedge i_mclk);
      chk("busy", 8'h00, {7'h00, o_busy});
      peek(8'hFE, 8'h11);
      peek(8'hFF, 8'h22);
      $display("test undefined command done");
   endtask
   task t_copy();
      sa(AW, 1'b1);
      wb(8'h05);
      chk("busy", 8'h00, {7'h00, o_busy});
      cgcmd_master_i.stop();
      wait_busy(1'b1, 200);
      sa(AW, 1'b0);
      cgcmd_master_i.stop();
      wait_busy(1'b0, 20000);
      sa(AW, 1'b1);
      cgcmd_master_i.stop();
      sa(AW, 1'b1);
      wb(8'h00);
      wb(8'hFE);
      wb(8'h99);
      cgcmd_master_i.stop();
      peek(8'hFE, 8'h99);
      sa(AW, 1'b1);
      wb(8'hFE);
      cgcmd_master_i.stop();
      wait_busy(1'b1, 200);
      wait_busy(1'b0, 5000);
      peek(8'hFE, 8'h11);
      peek(8'h01, 8'h44);
      $display("test save and restore done");
   endtask
   // -------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------
   initial
   begin
      i_reset <= 1'b1;
      repeat (12) @(posedge i_mclk);
      i_reset <= 1'b0;
      t_powerup();
      t_addr();
      t_write();
      t_read();
      t_undef();
      t_copy();
      end_of_test();
   end
   initial
   begin
      repeat (100000) @(posedge i_mclk);
      fail_count++;
      $display("BAD run expected end seen timeout");
      end_of_test();
   end
endmodule
